// File: design/aoc_pkg.sv
// Summary of operation
// - standby reset only for standby alarm types
// - two reset conditions, A default, B power-up
// - condition A re-arms on start or settings
// - remote set point change never re-arms standby
// - auxiliary alarm functions off in configuration levels, burnout output only in initial level
// - open-in-alarm inverts auxiliary output, close default
// - indicators follow function state, ignore polarity
// - burnout alarm enable, default on
// - burnout latch held until one clear event: key, cancel event, zero threshold or disable
// - latched burnout output off in initial level
// - burnout hysteresis 0.1 to 50 A, unlatched
// - alarm latch held until power or cancel
`default_nettype none
package aoc_pkg;
  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TYPE = 8'h04;
  localparam logic [7:0] OFF_HB = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;

  // control register fields
  localparam int CTRL_RSEL_BIT = 0;
  localparam int CTRL_BOEN_BIT = 1;
  localparam int CTRL_BOLAT_BIT = 2;
  localparam int CTRL_ALAT_LSB = 4;
  localparam int CTRL_POL_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0ff7;

  // alarm type register: four 4-bit type codes
  localparam int TYPE_W = 4;
  localparam logic [31:0] TYPE_RST = 32'h0000_0000;

  // burnout register: threshold and hysteresis in 0.1 A units
  localparam int HB_THR_LSB = 0;
  localparam int HB_HYS_LSB = 16;
  localparam logic [15:0] HB_THR_RST = 16'h0000;
  localparam logic [15:0] HB_HYS_MIN = 16'h0001;
  localparam logic [15:0] HB_HYS_MAX = 16'h01f4;

  // level register, status and interrupt layout
  localparam int LVL_LSB = 0;
  localparam int STAT_IND_LSB = 0;
  localparam int STAT_AUX_LSB = 4;
  localparam int STAT_BO_BIT = 8;
  localparam int N_ALM = 4;
  localparam int N_IRQ = 5;
  localparam int IRQ_BO_BIT = 4;
  localparam logic [4:0] INT_RST = 5'h00;

  // standby reset selection codes
  localparam logic RSEL_A = 1'b0;
  localparam logic RSEL_B = 1'b1;

  typedef enum logic [2:0] {LVL_OPER, LVL_INIT, LVL_COMM, LVL_ADV, LVL_CAL} aoc_level_t;

  typedef struct packed {
    logic [TYPE_W-1:0] alm_type;
    logic latch_en;
    logic rst_sel;
  } aoc_chan_cfg_t;

  typedef struct packed {
    logic rearm;
    logic cancel;
  } aoc_evt_t;

  typedef struct packed {
    logic [15:0] hys;
    logic [15:0] thr;
  } aoc_hb_cfg_t;

  // alarm types that carry a standby sequence
  function automatic logic is_standby_type(input logic [TYPE_W-1:0] t);
    return t inside {4'h5, 4'h6, 4'h7, 4'ha, 4'hb};
  endfunction : is_standby_type

  // configuration levels in which auxiliary alarm functions are forced off
  function automatic logic is_off_level(input aoc_level_t l);
    return l != LVL_OPER;
  endfunction : is_off_level
endpackage : aoc_pkg
`default_nettype wire

// File: design/aoc_alarm_chan.sv
`timescale 1ns/1ps
`default_nettype none
module aoc_alarm_chan (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // settings and events
  input wire aoc_pkg::aoc_chan_cfg_t cfg_in,
  input wire aoc_pkg::aoc_evt_t evt_in,
  // raw comparison and conditioned function state
  input wire logic raw_in,
  output logic cond_out
);
  typedef struct packed {
    logic armed;
    logic latched;
  } aoc_chan_st_t;

  aoc_chan_st_t st_q;
  aoc_chan_st_t st_d;
  logic sb_type;
  logic live;

  ////////////////////////////////////////////////////////////////////////////
  // standby suppression, latch and re-arm
  always_comb begin
    sb_type = aoc_pkg::is_standby_type(cfg_in.alm_type);
    live = raw_in & !(sb_type & st_q.armed);
    cond_out = live | (cfg_in.latch_en & st_q.latched & !evt_in.cancel);
    st_d = st_q;
    if (sb_type & evt_in.rearm & (cfg_in.rst_sel == aoc_pkg::RSEL_A)) begin
      st_d.armed = 1'b1;
    end else if (!raw_in) begin
      st_d.armed = 1'b0; // out of alarm region ends standby
    end
    st_d.latched = cfg_in.latch_en & cond_out;
  end

  // power-up arms the standby sequence
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{armed: 1'b1, latched: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  plain_pass_a:
    assert property (!sb_type & !cfg_in.latch_en |-> cond_out == raw_in)
    else $error("non-standby alarm not passed through");
  rearm_sel_a:
    assert property (sb_type & evt_in.rearm & cfg_in.rst_sel == aoc_pkg::RSEL_A
      |=> !raw_in or !cond_out or cfg_in.latch_en)
    else $error("standby not re-armed under condition A");
  sel_b_hold_a:
    assert property (!st_q.armed & cfg_in.rst_sel == aoc_pkg::RSEL_B |=> !st_q.armed)
    else $error("condition B re-armed after power-up");
  latch_hold_a:
    assert property (cfg_in.latch_en & cond_out & !evt_in.cancel ##1
      cfg_in.latch_en & !evt_in.cancel |-> cond_out)
    else $error("latched alarm dropped without cancel");
  standby_rearm_c: cover property (sb_type & st_q.armed & raw_in ##1 !raw_in);
endmodule : aoc_alarm_chan
`default_nettype wire

// File: design/aoc_top.sv
`timescale 1ns/1ps
`default_nettype none
module aoc_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // measurement path
  input wire logic [3:0] alarm_raw_in,
  input wire logic [15:0] heater_current_in,
  // control events
  input wire logic control_start_in,
  input wire logic param_change_in,
  input wire logic remote_sp_change_in,
  input wire logic function_key_in,
  input wire logic latch_cancel_event_in,
  // outputs and indicators
  output logic [3:0] aux_drive_out,
  output logic [3:0] aux_indicator_out,
  output logic heater_burnout_alarm_out,
  output logic irq_out
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] types;
    aoc_pkg::aoc_hb_cfg_t hb;
    aoc_pkg::aoc_level_t level;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
    logic bo_det;
    logic [4:0] prev_evt;
    logic [3:0] aux_drive;
    logic [3:0] aux_ind;
    logic bo_out;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aoc_state_t;

  aoc_state_t st_q;
  aoc_state_t st_d;

  aoc_pkg::aoc_chan_cfg_t chan_cfg [aoc_pkg::N_ALM];
  aoc_pkg::aoc_evt_t evt;
  logic [3:0] func;
  logic [3:0] func_gated;
  logic cancel;
  logic off_lvl;
  logic bo_en;
  logic bo_latch;
  logic thr_zero;
  logic low_cur;
  logic below_hys;
  logic [16:0] hys_edge;
  logic setup_ph;
  logic wr_en;
  logic [15:0] hys_wr;
  logic [31:0] hb_wr;
  logic [4:0] evt_now;
  logic [4:0] w1c;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // address decode for mapped words
  function automatic logic mapped(input logic [7:0] a);
    return a inside {aoc_pkg::OFF_CTRL, aoc_pkg::OFF_TYPE, aoc_pkg::OFF_HB,
                     aoc_pkg::OFF_LEVEL, aoc_pkg::OFF_STATUS, aoc_pkg::OFF_INT_STAT,
                     aoc_pkg::OFF_INT_MASK};
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // shared events for all alarm channels
  assign cancel = function_key_in | latch_cancel_event_in;
  assign evt = '{rearm: control_start_in | param_change_in, cancel: cancel};

  // four alarm channels
  generate
    for (genvar i = 0; i < aoc_pkg::N_ALM; i++) begin : g_chan
      assign chan_cfg[i] = '{
        alm_type: st_q.types[i*aoc_pkg::TYPE_W +: aoc_pkg::TYPE_W],
        latch_en: st_q.ctrl[aoc_pkg::CTRL_ALAT_LSB + i],
        rst_sel: st_q.ctrl[aoc_pkg::CTRL_RSEL_BIT]};
      aoc_alarm_chan u_chan (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .cfg_in(chan_cfg[i]),
        .evt_in(evt),
        .raw_in(alarm_raw_in[i]),
        .cond_out(func[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // burnout detection terms
  always_comb begin
    off_lvl = aoc_pkg::is_off_level(st_q.level);
    bo_en = st_q.ctrl[aoc_pkg::CTRL_BOEN_BIT];
    bo_latch = st_q.ctrl[aoc_pkg::CTRL_BOLAT_BIT];
    thr_zero = st_q.hb.thr == aoc_pkg::HB_THR_RST;
    low_cur = heater_current_in <= st_q.hb.thr;
    hys_edge = {1'b0, st_q.hb.thr} + {1'b0, st_q.hb.hys};
    below_hys = {1'b0, heater_current_in} < hys_edge;
    func_gated = off_lvl ? 4'h0 : func;
    setup_ph = psel_in & !penable_in;
    wr_en = psel_in & penable_in & st_q.pready & pwrite_in;
    hb_wr = merge({st_q.hb}, pwdata_in, pstrb_in);
    hys_wr = hb_wr[aoc_pkg::HB_HYS_LSB +: 16];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: registers, burnout, outputs, interrupts
  always_comb begin
    st_d = st_q;
    w1c = 5'h00;
    // bus writes at the access edge
    if (wr_en) begin
      unique case (paddr_in)
        aoc_pkg::OFF_CTRL: begin
          st_d.ctrl = merge(st_q.ctrl, pwdata_in, pstrb_in) & aoc_pkg::CTRL_MASK;
        end
        aoc_pkg::OFF_TYPE: begin
          st_d.types = merge(st_q.types, pwdata_in, pstrb_in) & 32'h0000_ffff;
        end
        aoc_pkg::OFF_HB: begin
          st_d.hb = merge({st_q.hb}, pwdata_in, pstrb_in);
          if (hys_wr < aoc_pkg::HB_HYS_MIN) begin
            st_d.hb.hys = aoc_pkg::HB_HYS_MIN;
          end else if (hys_wr > aoc_pkg::HB_HYS_MAX) begin
            st_d.hb.hys = aoc_pkg::HB_HYS_MAX;
          end
        end
        aoc_pkg::OFF_LEVEL: begin
          if (pstrb_in[0] && pwdata_in[aoc_pkg::LVL_LSB +: 3] <= 3'(aoc_pkg::LVL_CAL)) begin
            st_d.level = aoc_pkg::aoc_level_t'(pwdata_in[aoc_pkg::LVL_LSB +: 3]);
          end
        end
        aoc_pkg::OFF_INT_STAT: begin
          w1c = pstrb_in[0] ? pwdata_in[4:0] : 5'h00;
        end
        aoc_pkg::OFF_INT_MASK: begin
          if (pstrb_in[0]) begin
            st_d.int_mask = pwdata_in[4:0];
          end
        end
        default: begin
        end
      endcase
    end
    // heater burnout detection with latch or hysteresis
    if (!bo_en || thr_zero) begin
      st_d.bo_det = 1'b0;
    end else if (bo_latch) begin
      st_d.bo_det = low_cur | (st_q.bo_det & !cancel);
    end else if (st_q.bo_det) begin
      st_d.bo_det = below_hys;
    end else begin
      st_d.bo_det = low_cur;
    end
    // output stage
    st_d.aux_ind = func_gated;
    st_d.aux_drive = func_gated ^ st_q.ctrl[aoc_pkg::CTRL_POL_LSB +: 4];
    st_d.bo_out = st_d.bo_det & (st_q.level != aoc_pkg::LVL_INIT);
    // sticky interrupt status, set wins over clear
    evt_now = {st_d.bo_out, func_gated};
    st_d.prev_evt = evt_now;
    st_d.int_stat = (st_q.int_stat & ~w1c) | (evt_now & ~st_q.prev_evt);
    st_d.irq = |(st_d.int_stat & st_d.int_mask);
    // apb answer prepared in the setup cycle
    st_d.pready = setup_ph;
    st_d.pslverr = setup_ph & !mapped(paddr_in);
    st_d.prdata = 32'h0000_0000;
    if (setup_ph && !pwrite_in) begin
      unique case (paddr_in)
        aoc_pkg::OFF_CTRL: st_d.prdata = st_q.ctrl;
        aoc_pkg::OFF_TYPE: st_d.prdata = st_q.types;
        aoc_pkg::OFF_HB: st_d.prdata = {st_q.hb};
        aoc_pkg::OFF_LEVEL: st_d.prdata = {29'h0, st_q.level};
        aoc_pkg::OFF_STATUS: begin
          st_d.prdata = {23'h0, st_q.bo_out, st_q.aux_drive, st_q.aux_ind};
        end
        aoc_pkg::OFF_INT_STAT: st_d.prdata = {27'h0, st_q.int_stat};
        aoc_pkg::OFF_INT_MASK: st_d.prdata = {27'h0, st_q.int_mask};
        default: st_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
      st_q.ctrl <= aoc_pkg::CTRL_RST;
      st_q.types <= aoc_pkg::TYPE_RST;
      st_q.hb <= '{hys: aoc_pkg::HB_HYS_MIN, thr: aoc_pkg::HB_THR_RST};
      st_q.level <= aoc_pkg::LVL_OPER;
      st_q.int_stat <= aoc_pkg::INT_RST;
      st_q.int_mask <= aoc_pkg::INT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata_out = st_q.prdata;
  assign pready_out = st_q.pready;
  assign pslverr_out = st_q.pslverr;
  assign aux_drive_out = st_q.aux_drive;
  assign aux_indicator_out = st_q.aux_ind;
  assign heater_burnout_alarm_out = st_q.bo_out;
  assign irq_out = st_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  level_off_a:
    assert property (off_lvl |=> aux_indicator_out == 4'h0)
    else $error("alarm function not forced off in configuration level");
  aux_polarity_a:
    assert property (##1 aux_drive_out ==
      (aux_indicator_out ^ $past(st_q.ctrl[aoc_pkg::CTRL_POL_LSB +: 4])))
    else $error("auxiliary output polarity wrong");
  aux_indicator_a:
    assert property (rst_n_in & !off_lvl |=> aux_indicator_out == $past(func)) // not at release
    else $error("indicator does not follow function state");
  bo_disable_a:
    assert property (!bo_en |=> !heater_burnout_alarm_out)
    else $error("burnout alarm raised while disabled");
  bo_zero_clear_a:
    assert property (thr_zero |=> !st_q.bo_det ##1 !heater_burnout_alarm_out or !thr_zero)
    else $error("zero threshold did not clear burnout");
  bo_latch_hold_a:
    assert property (bo_en & bo_latch & !thr_zero & st_q.bo_det & !cancel |=> st_q.bo_det)
    else $error("latched burnout released without clear event");
  bo_init_off_a:
    assert property (st_q.level == aoc_pkg::LVL_INIT |=> !heater_burnout_alarm_out)
    else $error("burnout output on in initial level");
  bo_hyst_hold_a:
    assert property (bo_en & !bo_latch & !thr_zero & st_q.bo_det & below_hys
      |=> st_q.bo_det)
    else $error("burnout released inside hysteresis band");
  hys_range_a:
    assert property (st_q.hb.hys >= aoc_pkg::HB_HYS_MIN && st_q.hb.hys <= aoc_pkg::HB_HYS_MAX)
    else $error("burnout hysteresis out of range");
  same_cycle_a:
    assert property (rst_n_in & !off_lvl & alarm_raw_in[0]
      & !aoc_pkg::is_standby_type(st_q.types[3:0])
      |=> aux_indicator_out[0])
    else $error("raw alarm not conditioned in one cycle");
  irq_level_a:
    assert property (irq_out == |(st_q.int_stat & st_q.int_mask))
    else $error("interrupt output disagrees with status and mask");
  apb_answer_a:
    assert property (psel_in & !penable_in |=> pready_out ##1 !pready_out)
    else $error("apb answer not given in first access cycle");

  bo_latch_c: cover property (bo_latch & st_q.bo_det & !low_cur ##1 st_q.bo_det);
  open_alarm_c: cover property (aux_indicator_out[0] & !aux_drive_out[0]);
  irq_c: cover property (irq_out ##[1:20] !irq_out);
endmodule : aoc_top
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic irq;
  logic bo;
  logic [3:0] raw = 4'hf;
  logic [3:0] drv;
  logic [3:0] ind;
  logic [15:0] cur = 16'hffff;
  logic [4:0] evs = 5'h00;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] r;
  logic [3:0] pol;
  int ks[5] = '{2, 1, 0, 1, 0};
  logic ex[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  // clock, 20 ns period
  always #10 clk = ~clk;

  aoc_top i_aoc_top (
    .ref_clk_in(clk), .rst_n_in(rst_n),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .pstrb_in(4'hf), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .alarm_raw_in(raw), .heater_current_in(cur),
    .control_start_in(evs[0]), .param_change_in(evs[1]), .remote_sp_change_in(evs[2]),
    .function_key_in(evs[3]), .latch_cancel_event_in(evs[4]),
    .aux_drive_out(drv), .aux_indicator_out(ind),
    .heater_burnout_alarm_out(bo), .irq_out(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [3:0] exp_ind(input logic [3:0] a, input int lv);
    return (lv != 0) ? 4'h0 : a;
  endfunction : exp_ind

  function automatic logic [3:0] exp_drv(input logic [3:0] a, input logic [3:0] p, input int lv);
    return exp_ind(a, lv) ^ p;
  endfunction : exp_drv

  ////////////////////////////////////////////////////////////////////////////
  // report and bus tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // request held until the rising edge that samples pready high
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask : rdc

  // outputs lag inputs by one edge; give them room
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // one-cycle pulse on event input k
  task automatic ev(input int k);
    @(posedge clk);
    evs <= 5'h01 << k;
    @(posedge clk);
    evs <= 5'h00;
  endtask : ev

  task automatic set_in(input logic [3:0] a, input logic [15:0] c);
    @(posedge clk);
    raw <= a;
    cur <= c;
    settle;
  endtask : set_in

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    r = $urandom(32'h1660);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl", aoc_pkg::OFF_CTRL, 32'h0000_0002, 1'b0);
    rdc("type", aoc_pkg::OFF_TYPE, 32'h0000_0000, 1'b0);
    rdc("hb", aoc_pkg::OFF_HB, 32'h0001_0000, 1'b0);
    rdc("level", aoc_pkg::OFF_LEVEL, 32'h0000_0000, 1'b0);
    rdc("int_mask", aoc_pkg::OFF_INT_MASK, 32'h0000_0000, 1'b0);
    rdc("unmapped", 8'h1c, 32'h0000_0000, 1'b1);
    $display("test reset done");
    // standby sequence, alarm 1 armed since reset with raw held high
    wr(aoc_pkg::OFF_TYPE, 32'h0000_0005);
    settle;
    chk("ind0 armed", {31'h0, ind[0]}, 32'h0);
    chk("ind1 plain", {31'h0, ind[1]}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) wr(aoc_pkg::OFF_CTRL, 32'h0000_0003);
      set_in(4'he, 16'hffff);
      set_in(4'hf, 16'hffff);
      ev(ks[i]);
      settle;
      chk("ind0 rearm", {31'h0, ind[0]}, {31'h0, ex[i]});
    end
    $display("test standby done");
    // random polarity and alarm states
    wr(aoc_pkg::OFF_TYPE, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      pol = r[3:0];
      wr(aoc_pkg::OFF_CTRL, {20'h0, pol, 8'h02});
      set_in(r[7:4], 16'hffff);
      chk("ind", {28'h0, ind}, {28'h0, exp_ind(r[7:4], 0)});
      chk("drv", {28'h0, drv}, {28'h0, exp_drv(r[7:4], pol, 0)});
    end
    for (int lv = 1; lv <= 4; lv++) begin
      wr(aoc_pkg::OFF_LEVEL, lv);
      settle;
      chk("ind lvl", {28'h0, ind}, {28'h0, exp_ind(raw, lv)});
      chk("drv lvl", {28'h0, drv}, {28'h0, exp_drv(raw, pol, lv)});
    end
    wr(aoc_pkg::OFF_LEVEL, 32'h0000_0005);
    rdc("level", aoc_pkg::OFF_LEVEL, 32'h0000_0004, 1'b0);
    wr(aoc_pkg::OFF_LEVEL, 32'h0000_0000);
    $display("test polarity done");
    // alarm 2 latch, both cancel sources
    wr(aoc_pkg::OFF_CTRL, 32'h0000_0022);
    for (int k = 3; k <= 4; k++) begin
      set_in(4'h2, 16'hffff);
      set_in(4'h0, 16'hffff);
      chk("ind1 held", {31'h0, ind[1]}, 32'h1);
      ev(k);
      settle;
      chk("ind1 cancel", {31'h0, ind[1]}, 32'h0);
    end
    $display("test alarm latch done");
    // interrupts: masked alarm rise, unmasked burnout rise
    wr(aoc_pkg::OFF_INT_STAT, 32'h0000_001f);
    wr(aoc_pkg::OFF_INT_MASK, 32'h0000_0010);
    set_in(4'h4, 16'hffff);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc("int_stat", aoc_pkg::OFF_INT_STAT, 32'h0000_0004, 1'b0);
    // burnout threshold 2.0 A, hysteresis 0.5 A
    wr(aoc_pkg::OFF_HB, {16'd5, 16'd20});
    set_in(4'h4, 16'd10);
    chk("bo on", {31'h0, bo}, 32'h1);
    chk("irq bo", {31'h0, irq}, 32'h1);
    rdc("status", aoc_pkg::OFF_STATUS, 32'h0000_0144, 1'b0);
    set_in(4'h4, 16'd24);
    chk("bo hys", {31'h0, bo}, 32'h1);
    set_in(4'h4, 16'd25);
    chk("bo off", {31'h0, bo}, 32'h0);
    wr(aoc_pkg::OFF_INT_STAT, 32'h0000_0010);
    settle;
    chk("irq clear", {31'h0, irq}, 32'h0);
    wr(aoc_pkg::OFF_CTRL, 32'h0000_0000);
    set_in(4'h4, 16'd10);
    chk("bo disabled", {31'h0, bo}, 32'h0);
    $display("test burnout done");
    // latched burnout: key, event, zero threshold, initial level
    wr(aoc_pkg::OFF_CTRL, 32'h0000_0006);
    for (int k = 3; k <= 6; k++) begin
      wr(aoc_pkg::OFF_HB, {16'd5, 16'd20});
      set_in(4'h4, 16'd10);
      set_in(4'h4, 16'd100);
      chk("bo latched", {31'h0, bo}, 32'h1);
      if (k < 5) ev(k);
      if (k == 5) wr(aoc_pkg::OFF_HB, {16'd5, 16'd0});
      if (k == 6) wr(aoc_pkg::OFF_LEVEL, 32'h0000_0001);
      settle;
      chk("bo cleared", {31'h0, bo}, 32'h0);
    end
    wr(aoc_pkg::OFF_LEVEL, 32'h0000_0000);
    ev(3);
    wr(aoc_pkg::OFF_HB, 32'h0000_0000);
    rdc("hys min", aoc_pkg::OFF_HB, 32'h0001_0000, 1'b0);
    wr(aoc_pkg::OFF_HB, 32'hffff_0000);
    rdc("hys max", aoc_pkg::OFF_HB, 32'h01f4_0000, 1'b0);
    $display("test burnout latch done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
